/* rtl/ulpi_phy_params.svh */
// Offsets, field positions, reset values and timing counts for the
// low pin count link signalling block.
// Assumes a single 250 MHz system clock and byte-addressed registers.
`ifndef ULPI_PHY_PARAMS_SVH
`define ULPI_PHY_PARAMS_SVH

`define SYS_CLK_MHZ      250
`define LINK_CLK_MHZ     60
`define PHASE_MOD        8'd250
`define PHASE_STEP       8'd120

`define PLL_STARTUP_US   1
`define PLL_STARTUP_CYC  (`PLL_STARTUP_US * `LINK_CLK_MHZ)
`define VBUS_PULSE_US    10
`define VBUS_PULSE_CYC   (`VBUS_PULSE_US * `SYS_CLK_MHZ)

`define REG_STATUS       5'h00
`define REG_FUNC_CTRL    5'h04
`define REG_OTG_CTRL     5'h08
`define REG_TX_DATA      5'h0c
`define REG_RX_DATA      5'h10

`define FUNC_RESET_BIT   5
`define OTG_SUPPLY_BIT   0
`define OTG_EXTSEL_BIT   1
`define OTG_PULSE_BIT    2

`define OTG_CTRL_RESET   3'h0
`define RX_FIFO_DEPTH    4
`define RX_FIFO_WIDTH    9

`endif

/* rtl/ulpi_phy_pkg.sv */
// Types used by the link signalling block; its receive FIFO keeps its own.
// Widths are written out literally in the struct.
`include "ulpi_phy_params.svh"
package ulpi_phy_pkg;

  typedef enum logic [2:0] {
    LNK_STARTUP,
    LNK_TURN_DN,
    LNK_IDLE,
    LNK_RX,
    LNK_TURN_UP,
    LNK_SEND
  } link_state_e;

  typedef struct packed {
    logic [1:0]  stp_sync;
    logic [1:0]  ext_sync;
    logic [1:0]  id_sync;
    logic [1:0]  vcmp_sync;
    logic [1:0]  xrst_sync;
    logic [7:0]  data_s1;
    logic [7:0]  data_s2;
    logic [7:0]  phase;
    logic        link_clk;
    link_state_e st;
    logic [7:0]  startup_cnt;
    logic        dir;
    logic        nxt;
    logic [7:0]  dout;
    logic        doe_n;
    logic        hold_valid;
    logic [7:0]  hold_byte;
    logic        waitreq;
    logic [31:0] rdata;
    logic        supply_en;
    logic        ext_sel;
    logic        reset_req;
    logic [23:0] pulse_cnt;
    logic        pulse;
    logic        tx_pend;
    logic [7:0]  tx_byte;
  } phy_state_s;

endpackage : ulpi_phy_pkg

/* rtl/rx_fifo_if.sv */
// Carrier between the link logic and its receive FIFO.
// Single clock domain; no clocking.
`timescale 1ns/10ps
interface rx_fifo_if #(
  parameter int W = 9,
  parameter int D = 4
);
  logic                   push_valid;
  logic                   push_ready;
  logic [W-1:0]           push_data;
  logic                   pop_valid;
  logic                   pop_ready;
  logic [W-1:0]           pop_data;
  logic                   flush;
  logic [$clog2(D+1)-1:0] level;

  modport fill  (output push_valid, push_data, pop_ready, flush,
                 input  push_ready, pop_valid, pop_data, level);
  modport store (input  push_valid, push_data, pop_ready, flush,
                 output push_ready, pop_valid, pop_data, level);
endinterface : rx_fifo_if

/* rtl/rx_fifo.sv */
// Receive byte FIFO with valid/ready on both sides and flush.
// Assumes the same clock and synchronous reset as its user.
`timescale 1ns/10ps
module rx_fifo #(
  parameter int W = 9,
  parameter int D = 4
) (
  // Clock and reset
  input  wire logic sys_clk_in,
  input  wire logic resetn_in,
  // Queue ports
  rx_fifo_if.store  q
);
  localparam int PW = $clog2(D);
  localparam int CW = $clog2(D+1);

  typedef struct packed {
    logic [D-1:0][W-1:0] mem;
    logic [PW-1:0]       rd;
    logic [PW-1:0]       wr;
    logic [CW-1:0]       cnt;
  } fifo_state_s;

  fifo_state_s s;
  fifo_state_s next_s;
  logic        do_push;
  logic        do_pop;

  assign q.push_ready = (s.cnt != CW'(D));
  assign q.pop_valid  = (s.cnt != '0);
  assign q.pop_data   = s.mem[s.rd];
  assign q.level      = s.cnt;

  always_comb begin
    next_s  = s;
    do_push = q.push_valid && q.push_ready;
    do_pop  = q.pop_ready && q.pop_valid;
    if (do_push) begin
      next_s.mem[s.wr] = q.push_data;
      next_s.wr        = (s.wr == PW'(D-1)) ? '0 : s.wr + 1'b1;
    end
    if (do_pop) begin
      next_s.rd = (s.rd == PW'(D-1)) ? '0 : s.rd + 1'b1;
    end
    next_s.cnt = s.cnt + CW'(do_push) - CW'(do_pop);
    if (q.flush) begin
      next_s.rd  = '0;
      next_s.wr  = '0;
      next_s.cnt = '0;
    end
  end

  always_ff @(posedge sys_clk_in) begin
    if (!resetn_in) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end
endmodule : rx_fifo

/* rtl/ulpi_phy_link.sv */
// PHY-side signalling of the low pin count link: clock out, bus
// direction, byte throttle, stream stop and the side pins.
// Assumes a 250 MHz system clock, an Avalon-MM master with waitrequest,
// and a link-layer controller clocked by interface_clock_out.
`timescale 1ns/10ps
`include "ulpi_phy_params.svh"
module ulpi_phy_link #(
  parameter logic [23:0] VBUS_PULSE_CYCLES = 24'(`VBUS_PULSE_CYC)
) (
  // Clock and reset
  input  wire logic        sys_clk_in,
  input  wire logic        resetn_in,
  // Avalon-MM slave
  input  wire logic [4:0]  avs_address_in,
  input  wire logic        avs_read_in,
  input  wire logic        avs_write_in,
  input  wire logic [31:0] avs_writedata_in,
  output logic      [31:0] avs_readdata_out,
  output logic             avs_waitrequest_out,
  // Link pins
  output logic             interface_clock_out,
  output logic             dir_out,
  output logic             nxt_out,
  input  wire logic        stp_in,
  input  wire logic [7:0]  data_in,
  output logic      [7:0]  data_out,
  output logic             data_oe_n_out,
  // Side pins
  output logic             ext_supply_enable_out,
  input  wire logic        external_vbus_detect_in,
  input  wire logic        vbus_comparator_in,
  input  wire logic        xcvr_reset_in,
  input  wire logic        id_in,
  output logic             vbus_pulse_out
);
  localparam int CW = $clog2(`RX_FIFO_DEPTH + 1);

  ulpi_phy_pkg::phy_state_s s;
  ulpi_phy_pkg::phy_state_s next_s;

  rx_fifo_if #(.W(`RX_FIFO_WIDTH), .D(`RX_FIFO_DEPTH)) rxq ();

  rx_fifo #(
    .W (`RX_FIFO_WIDTH),
    .D (`RX_FIFO_DEPTH)
  ) u_rx_fifo (
    .sys_clk_in (sys_clk_in),
    .resetn_in  (resetn_in),
    .q          (rxq.store)
  );

  logic       link_rise;
  logic       wrap;
  logic [8:0] phase_sum;
  logic       xrst;
  logic       bus_req;
  logic       bus_ack;
  logic       room2;
  logic       room3;
  logic       push_v;
  logic [8:0] push_d;
  logic       pop_r;
  logic       flush;
  logic       vbus_valid;

  assign rxq.push_valid = push_v;
  assign rxq.push_data  = push_d;
  assign rxq.pop_ready  = pop_r;
  assign rxq.flush      = flush;

  assign avs_readdata_out      = s.rdata;
  assign avs_waitrequest_out   = s.waitreq;
  assign interface_clock_out   = s.link_clk;
  assign dir_out               = s.dir;
  assign nxt_out               = s.nxt;
  assign data_out              = s.dout;
  assign data_oe_n_out         = s.doe_n;
  assign ext_supply_enable_out = s.supply_en;
  assign vbus_pulse_out        = s.pulse;

  always_comb begin
    next_s = s;
    push_v = 1'b0;
    push_d = '0;
    pop_r  = 1'b0;
    flush  = 1'b0;

    // Pin synchronisers
    next_s.stp_sync  = {s.stp_sync[0], stp_in};
    next_s.ext_sync  = {s.ext_sync[0], external_vbus_detect_in};
    next_s.id_sync   = {s.id_sync[0], id_in};
    next_s.vcmp_sync = {s.vcmp_sync[0], vbus_comparator_in};
    next_s.xrst_sync = {s.xrst_sync[0], xcvr_reset_in};
    next_s.data_s1   = data_in;
    next_s.data_s2   = s.data_s1;

    // Fractional divider: 120/250 toggles per cycle gives 60 MHz
    phase_sum = {1'b0, s.phase} + {1'b0, `PHASE_STEP};
    wrap      = (phase_sum >= {1'b0, `PHASE_MOD});
    if (wrap) begin
      next_s.phase    = 8'(phase_sum - {1'b0, `PHASE_MOD});
      next_s.link_clk = ~s.link_clk;
    end else begin
      next_s.phase = phase_sum[7:0];
    end
    link_rise = wrap && !s.link_clk;

    vbus_valid = s.ext_sel ? s.ext_sync[1] : s.vcmp_sync[1];
    xrst       = s.xrst_sync[1] || s.reset_req;
    room2      = (CW'(`RX_FIFO_DEPTH) - rxq.level) >= CW'(2);
    room3      = (CW'(`RX_FIFO_DEPTH) - rxq.level) >= CW'(3);

    // Link side, stepped on each interface clock rising edge
    if (link_rise) begin
      if (xrst) begin
        next_s.st          = ulpi_phy_pkg::LNK_STARTUP;
        next_s.startup_cnt = '0;
        next_s.dir         = 1'b1;
        next_s.nxt         = 1'b0;
        next_s.doe_n       = 1'b1;
        next_s.hold_valid  = 1'b0;
        next_s.reset_req   = 1'b0;
        flush              = 1'b1;
      end else begin
        unique case (s.st)
          ulpi_phy_pkg::LNK_STARTUP: begin
            next_s.dir   = 1'b1;
            next_s.doe_n = 1'b1;
            next_s.startup_cnt = s.startup_cnt + 8'h01;
            if (s.startup_cnt == 8'(`PLL_STARTUP_CYC - 1)) begin
              next_s.dir = 1'b0;
              next_s.st  = ulpi_phy_pkg::LNK_TURN_DN;
            end
          end
          ulpi_phy_pkg::LNK_TURN_DN: begin
            next_s.st = ulpi_phy_pkg::LNK_IDLE;
          end
          ulpi_phy_pkg::LNK_IDLE: begin
            next_s.dir   = 1'b0;
            next_s.doe_n = 1'b1;
            if (s.data_s2 != 8'h00) begin
              next_s.st  = ulpi_phy_pkg::LNK_RX;
              next_s.nxt = room2;
            end else if (s.tx_pend) begin
              next_s.dir = 1'b1;
              next_s.st  = ulpi_phy_pkg::LNK_TURN_UP;
            end
          end
          ulpi_phy_pkg::LNK_RX: begin
            if (s.stp_sync[1]) begin
              // Held byte was on the bus just before the stop
              if (s.hold_valid) begin
                push_v = 1'b1;
                push_d = {1'b1, s.hold_byte};
              end
              next_s.hold_valid = 1'b0;
              next_s.nxt        = 1'b0;
              next_s.st         = ulpi_phy_pkg::LNK_IDLE;
            end else begin
              if (s.nxt) begin
                if (s.hold_valid) begin
                  push_v = 1'b1;
                  push_d = {1'b0, s.hold_byte};
                end
                next_s.hold_valid = 1'b1;
                next_s.hold_byte  = s.data_s2;
              end
              // A push now takes a slot; the held byte needs one later
              next_s.nxt = push_v ? room3 : room2;
            end
          end
          ulpi_phy_pkg::LNK_TURN_UP: begin
            next_s.dout  = s.tx_byte;
            next_s.doe_n = 1'b0;
            next_s.st    = ulpi_phy_pkg::LNK_SEND;
          end
          ulpi_phy_pkg::LNK_SEND: begin
            next_s.tx_pend = 1'b0;
            next_s.dir     = 1'b0;
            next_s.doe_n   = 1'b1;
            next_s.st      = ulpi_phy_pkg::LNK_TURN_DN;
          end
        endcase
      end
    end

    // Session request pulse on vbus
    if (s.pulse_cnt != 24'h000000) begin
      next_s.pulse_cnt = s.pulse_cnt - 24'h000001;
    end
    next_s.pulse = (next_s.pulse_cnt != 24'h000000);

    // Avalon-MM slave: one wait cycle, answer on the next edge
    bus_req = avs_read_in || avs_write_in;
    bus_ack = bus_req && !s.waitreq;
    next_s.waitreq = !(bus_req && s.waitreq);
    if (bus_req && s.waitreq) begin
      next_s.rdata = '0;
      if (avs_read_in) begin
        unique case (avs_address_in)
          `REG_STATUS: begin
            next_s.rdata[0]    = s.dir;
            next_s.rdata[1]    = s.id_sync[1];
            next_s.rdata[2]    = vbus_valid;
            next_s.rdata[3]    = (s.st != ulpi_phy_pkg::LNK_STARTUP);
            next_s.rdata[4]    = s.tx_pend;
            next_s.rdata[5]    = rxq.pop_valid;
            next_s.rdata[6]    = s.pulse;
            next_s.rdata[10:8] = 3'(rxq.level);
          end
          `REG_FUNC_CTRL: begin
            next_s.rdata[`FUNC_RESET_BIT] = s.reset_req;
          end
          `REG_OTG_CTRL: begin
            next_s.rdata[`OTG_SUPPLY_BIT] = s.supply_en;
            next_s.rdata[`OTG_EXTSEL_BIT] = s.ext_sel;
            next_s.rdata[`OTG_PULSE_BIT]  = s.pulse;
          end
          `REG_TX_DATA: begin
            next_s.rdata[7:0] = s.tx_byte;
          end
          `REG_RX_DATA: begin
            next_s.rdata[8:0] = rxq.pop_valid ? rxq.pop_data : 9'h000;
            next_s.rdata[9]   = rxq.pop_valid;
          end
          default: begin
            next_s.rdata = '0;
          end
        endcase
      end
    end
    if (bus_ack && avs_read_in && avs_address_in == `REG_RX_DATA) begin
      // Pop only a word that this read reported as valid
      pop_r = s.rdata[9] && rxq.pop_valid && !flush;
    end
    if (bus_ack && avs_write_in) begin
      unique case (avs_address_in)
        `REG_FUNC_CTRL: begin
          if (avs_writedata_in[`FUNC_RESET_BIT]) begin
            next_s.reset_req = 1'b1;
          end
        end
        `REG_OTG_CTRL: begin
          next_s.supply_en = avs_writedata_in[`OTG_SUPPLY_BIT];
          next_s.ext_sel   = avs_writedata_in[`OTG_EXTSEL_BIT];
          if (avs_writedata_in[`OTG_PULSE_BIT]) begin
            next_s.pulse_cnt = VBUS_PULSE_CYCLES;
          end
        end
        `REG_TX_DATA: begin
          if (!s.tx_pend) begin
            next_s.tx_pend = 1'b1;
            next_s.tx_byte = avs_writedata_in[7:0];
          end
        end
        default: begin
          next_s.tx_pend = next_s.tx_pend;
        end
      endcase
    end
  end

  always_ff @(posedge sys_clk_in) begin
    if (!resetn_in) begin
      s             <= '0;
      s.st          <= ulpi_phy_pkg::LNK_STARTUP;
      s.dir         <= 1'b1;
      s.doe_n       <= 1'b1;
      s.waitreq     <= 1'b1;
      s.supply_en   <= 1'b0;
    end else begin
      s <= next_s;
    end
  end
endmodule : ulpi_phy_link

/* dv/ulpi_phy_link_properties.sv */
// Port-level checks for the link signalling block.
// Assumes reset is held low at start; bound to the block below.
`timescale 1ns/10ps
module ulpi_phy_link_props #(
  parameter logic [23:0] VBUS_PULSE_CYCLES = 24'h9c4
) (
  // Clock and reset
  input wire logic       sys_clk_in,
  input wire logic       resetn_in,
  // Register bus
  input wire logic       avs_read_in,
  input wire logic       avs_write_in,
  input wire logic       avs_waitrequest_out,
  // Link and side pins
  input wire logic       interface_clock_out,
  input wire logic       dir_out,
  input wire logic       nxt_out,
  input wire logic [7:0] data_out,
  input wire logic       data_oe_n_out,
  input wire logic       ext_supply_enable_out,
  input wire logic       xcvr_reset_in,
  input wire logic       vbus_pulse_out
);
  default clocking @(posedge sys_clk_in); endclocking
  default disable iff (!resetn_in);
  logic [23:0] pcnt;
  // Length of the current vbus pulse
  always_ff @(posedge sys_clk_in) begin
    if (!resetn_in || !vbus_pulse_out) pcnt <= 24'h0;
    else pcnt <= pcnt + 24'h1;
  end
  a_reset_values: assert property (
    $rose(resetn_in) |-> dir_out && data_oe_n_out && !ext_supply_enable_out)
    else $error("Link outputs not at reset values");
  a_edge_launch: assert property (
    $changed(dir_out) || $changed(nxt_out) || $changed(data_oe_n_out)
    || $changed(data_out) |-> $rose(interface_clock_out))
    else $error("Link output moved off the interface clock edge");
  a_drive_owner: assert property (
    !data_oe_n_out |-> dir_out)
    else $error("Data driven without bus ownership");
  a_turn_quiet: assert property (
    $changed(dir_out) |-> data_oe_n_out [*4])
    else $error("Data driven in turnaround");
  a_nxt_rx_only: assert property (
    nxt_out |-> !dir_out && data_oe_n_out)
    else $error("Accept strobe outside link transmit");
  a_xcvr_dir: assert property (
    xcvr_reset_in [*8] |-> ##[0:4] dir_out && !nxt_out)
    else $error("Bus not held during transceiver reset");
  a_wait_answer: assert property (
    (avs_read_in || avs_write_in) && avs_waitrequest_out
    |=> !avs_waitrequest_out)
    else $error("Bus request not answered after one wait");
  a_wait_single: assert property (
    !avs_waitrequest_out |=> avs_waitrequest_out)
    else $error("Wait release longer than one cycle");
  a_pulse_length: assert property (
    $fell(vbus_pulse_out) |-> pcnt >= VBUS_PULSE_CYCLES - 24'h1
    && pcnt <= VBUS_PULSE_CYCLES + 24'h1)
    else $error("Vbus pulse length wrong");
endmodule : ulpi_phy_link_props

bind ulpi_phy_link ulpi_phy_link_props #(
  .VBUS_PULSE_CYCLES(VBUS_PULSE_CYCLES)
) i_props (.sys_clk_in, .resetn_in, .avs_read_in, .avs_write_in,
  .avs_waitrequest_out, .interface_clock_out, .dir_out, .nxt_out,
  .data_out, .data_oe_n_out, .ext_supply_enable_out, .xcvr_reset_in,
  .vbus_pulse_out);

/* dv/link_model.sv */
// Link-layer controller model facing the block's link pins.
// Clocked by the interface clock; the bench resolves the shared bus.
`timescale 1ns/10ps
module link_model (
  // Link pins
  input  wire logic       lclk_in,
  input  wire logic       dir_in,
  input  wire logic       nxt_in,
  input  wire logic       oe_n_in,
  input  wire logic [7:0] bus_in,
  output logic            stp_out,
  output logic            drive_out,
  output logic      [7:0] data_out
);
  logic [7:0] txq[$];
  logic [7:0] seen[$];
  logic       act = 1'b0;
  logic       dir_s = 1'b1;
  logic       dir_p = 1'b1;
  logic       nxt_s = 1'b0;
  initial begin
    stp_out = 1'b0;
    drive_out = 1'b0;
    data_out = 8'h00;
  end
  // Sample settled levels mid-cycle
  always @(negedge lclk_in) begin
    dir_p = dir_s;
    dir_s = dir_in;
    nxt_s = nxt_in;
    if (dir_in && !oe_n_in) seen.push_back(bus_in);
  end
  always @(posedge lclk_in) begin
    stp_out <= 1'b0;
    if (act && nxt_s) void'(txq.pop_front());
    if (act && nxt_s && txq.size() == 0) begin
      act <= 1'b0;
      drive_out <= 1'b0;
      stp_out <= 1'b1;
    end else if (act) begin
      data_out <= txq[0];
    end else if (txq.size() != 0 && !dir_s && !dir_p) begin
      act <= 1'b1;
      drive_out <= 1'b1;
      data_out <= txq[0];
    end
  end
endmodule : link_model

/* dv/ulpi_phy_link_tb.sv */
// Self-checking bench for the link signalling block.
// Assumes link_model as far side; data bus is pulled low when released.
`timescale 1ns/10ps
module ulpi_phy_link_tb;
  localparam logic [23:0] PULSE = 24'h14;
  logic sys_clk_in = 1'b0;
  logic resetn_in = 1'b0;
  logic [4:0] avs_address_in = 5'h00;
  logic avs_read_in = 1'b0;
  logic avs_write_in = 1'b0;
  logic [31:0] avs_writedata_in = 32'h0;
  logic [31:0] avs_readdata_out;
  logic avs_waitrequest_out, interface_clock_out, dir_out, nxt_out, stp_in;
  logic [7:0] data_out, lnk_d, b;
  logic data_oe_n_out, ext_supply_enable_out, vbus_pulse_out, lnk_drv;
  logic external_vbus_detect_in = 1'b0;
  logic vbus_comparator_in = 1'b0;
  logic xcvr_reset_in = 1'b0;
  logic id_in = 1'b0;
  wire [7:0] bus = !data_oe_n_out ? data_out : (lnk_drv ? lnk_d : 8'h00);
  int n_fail = 0;
  int n_checks = 0;
  int seed = 42;
  logic [31:0] s;
  logic [9:0] exp_q[$];

  always #2 sys_clk_in = ~sys_clk_in;

  ulpi_phy_link #(.VBUS_PULSE_CYCLES(PULSE)) i_dut (.sys_clk_in, .resetn_in,
    .avs_address_in, .avs_read_in, .avs_write_in, .avs_writedata_in,
    .avs_readdata_out, .avs_waitrequest_out, .interface_clock_out, .dir_out,
    .nxt_out, .stp_in, .data_in(bus), .data_out, .data_oe_n_out,
    .ext_supply_enable_out, .external_vbus_detect_in, .vbus_comparator_in,
    .xcvr_reset_in, .id_in, .vbus_pulse_out);
  link_model i_lnk (.lclk_in(interface_clock_out), .dir_in(dir_out),
    .nxt_in(nxt_out), .oe_n_in(data_oe_n_out), .bus_in(bus),
    .stp_out(stp_in), .drive_out(lnk_drv), .data_out(lnk_d));

  task automatic chk(input string nm, input logic [31:0] got, exp);
    n_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("ERROR %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk

  task automatic bus_op(input logic wr, input logic [4:0] a,
                        input logic [31:0] d);
    int n;
    n = 0;
    @(posedge sys_clk_in);
    avs_address_in <= a;
    avs_writedata_in <= d;
    avs_write_in <= wr;
    avs_read_in <= !wr;
    do begin
      @(posedge sys_clk_in);
      n++;
    end while (avs_waitrequest_out !== 1'b0 && n < 50);
    s = avs_readdata_out;
    avs_write_in <= 1'b0;
    avs_read_in <= 1'b0;
    chk("bus answer", 32'(n < 50), 32'h1);
  endtask : bus_op

  task automatic wait_up();
    for (int k = 0; k < 300; k++) begin
      bus_op(1'b0, 5'h00, 32'h0);
      if (s[3] === 1'b1) break;
    end
    repeat (20) @(posedge sys_clk_in);
  endtask : wait_up

  task automatic report_and_stop();
    $display("Checks %0d mismatches %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : report_and_stop

  initial begin
    repeat (3) @(posedge sys_clk_in);
    resetn_in <= 1'b1;
    @(posedge sys_clk_in);
    chk("supply", 32'(ext_supply_enable_out), 32'h0);
    chk("dir startup", 32'(dir_out), 32'h1);
    bus_op(1'b0, 5'h08, 32'h0);
    chk("otg reset", s, 32'h0);
    bus_op(1'b0, 5'h14, 32'h0);
    chk("unmapped", s, 32'h0);
    wait_up();
    chk("dir idle", 32'(dir_out), 32'h0);
    for (int i = 0; i < 8; i++) begin
      id_in <= 1'($random(seed));
      external_vbus_detect_in <= 1'($random(seed));
      vbus_comparator_in <= 1'($random(seed));
      bus_op(1'b1, 5'h08, 32'(i % 4));
      repeat (4) @(posedge sys_clk_in);
      bus_op(1'b0, 5'h00, 32'h0);
      chk("id", 32'(s[1]), 32'(id_in));
      chk("vbus sel", 32'(s[2]), 32'(i[1] ? external_vbus_detect_in
                                      : vbus_comparator_in));
      chk("supply pin", 32'(ext_supply_enable_out), 32'(i[0]));
    end
    bus_op(1'b1, 5'h08, 32'h4);
    for (int k = 0; k < 10 && vbus_pulse_out !== 1'b1; k++)
      @(posedge sys_clk_in);
    bus_op(1'b0, 5'h00, 32'h0);
    chk("pulse status", 32'(s[6]), 32'h1);
    repeat (PULSE + 10) @(posedge sys_clk_in);
    chk("pulse end", 32'(vbus_pulse_out), 32'h0);
    b = 8'($random(seed)) | 8'h01;
    bus_op(1'b1, 5'h0c, {24'h0, b});
    bus_op(1'b1, 5'h0c, {24'h0, ~b});
    repeat (100) @(posedge sys_clk_in);
    chk("sent count", i_lnk.seen.size(), 32'h1);
    chk("sent byte", 32'(i_lnk.seen[0]), 32'(b));
    for (int k = 0; k < 6; k++) begin
      b = (k == 0) ? (8'($random(seed)) | 8'h40) : 8'($random(seed));
      i_lnk.txq.push_back(b);
      exp_q.push_back({1'b1, k == 5, b});
    end
    for (int k = 0; k < 100; k++) begin
      bus_op(1'b0, 5'h00, 32'h0);
      if (s[10:8] === 3'h3) break;
    end
    repeat (40) @(posedge sys_clk_in);
    bus_op(1'b0, 5'h00, 32'h0);
    chk("fifo level", 32'(s[10:8]), 32'h3);
    // Three bytes queued, one held, two left waiting at the link
    chk("link held", i_lnk.txq.size(), 32'h2);
    for (int k = 0; k < 200 && exp_q.size() != 0; k++) begin
      bus_op(1'b0, 5'h10, 32'h0);
      if (s[9] === 1'b1) chk("rx word", 32'(s[9:0]), 32'(exp_q.pop_front()));
    end
    chk("rx drained", exp_q.size(), 32'h0);
    bus_op(1'b0, 5'h10, 32'h0);
    chk("rx empty", 32'(s[9]), 32'h0);
    bus_op(1'b1, 5'h08, 32'h3);
    xcvr_reset_in <= 1'b1;
    repeat (20) @(posedge sys_clk_in);
    chk("dir xcvr", 32'(dir_out), 32'h1);
    bus_op(1'b0, 5'h00, 32'h0);
    chk("started", 32'(s[3]), 32'h0);
    xcvr_reset_in <= 1'b0;
    bus_op(1'b0, 5'h08, 32'h0);
    chk("otg kept", 32'(s[1:0]), 32'h3);
    chk("supply kept", 32'(ext_supply_enable_out), 32'h1);
    wait_up();
    bus_op(1'b1, 5'h04, 32'h20);
    repeat (12) @(posedge sys_clk_in);
    chk("dir soft", 32'(dir_out), 32'h1);
    bus_op(1'b0, 5'h08, 32'h0);
    chk("otg soft", 32'(s[1:0]), 32'h3);
    wait_up();
    resetn_in <= 1'b0;
    repeat (3) @(posedge sys_clk_in);
    resetn_in <= 1'b1;
    @(posedge sys_clk_in);
    chk("supply rst", 32'(ext_supply_enable_out), 32'h0);
    report_and_stop();
  end

  // Run should end well before this
  initial begin
    repeat (60000) @(posedge sys_clk_in);
    n_fail++;
    report_and_stop();
  end
endmodule : ulpi_phy_link_tb
